// ===== logic/gcd_pkg.sv
// Package with register map, field positions and carrier types of the global configuration block.
package gcd_pkg;

    // Register addresses and access framing.
    localparam logic [7:0] GCD_ADDR_GLOBAL_CONFIGURATION = 8'h00;
    localparam logic [7:0] GCD_WRITE_FLAG                = 8'h80;
    localparam int         GCD_WRITE_BIT                 = 7;
    localparam int         GCD_CONF_WIDTH                = 17;
    localparam logic [16:0] GCD_CONF_RESET               = 17'h0_0000;

    // Field positions inside the global configuration register.
    localparam int GCD_B_SCALE_ANALOG      = 0;
    localparam int GCD_B_INTERNAL_SENSE    = 1;
    localparam int GCD_B_PWM_MODE          = 2;
    localparam int GCD_B_ENC_COMMUTATION   = 3;
    localparam int GCD_B_INVERT_DIRECTION  = 4;
    localparam int GCD_B_A_DRIVER_ERROR    = 5;
    localparam int GCD_B_A_PREWARNING      = 6;
    localparam int GCD_B_A_STALL_STEP      = 7;
    localparam int GCD_B_B_STALL_DIRECTION = 8;
    localparam int GCD_B_B_INDEX           = 9;
    localparam int GCD_B_B_CHOPPER_ON      = 10;
    localparam int GCD_B_B_TOGGLE_SKIP     = 11;
    localparam int GCD_B_A_PUSHPULL        = 12;
    localparam int GCD_B_B_PUSHPULL        = 13;

    // Register access request from the serial interface.
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [31:0] wdata;
    } gcd_req_t;

    // Read answer toward the serial interface.
    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } gcd_rsp_t;

    // Internal event sources; all but standstill, which gates the chopper mode, may be routed to the diagnostic outputs.
    typedef struct packed {
        logic overtemperature;
        logic short_to_ground;
        logic charge_pump_undervoltage;
        logic prewarning;
        logic stall;
        logic index;
        logic chopper_on;
        logic skip_increment;
        logic interrupt;
        logic position_compare;
        logic step_toggle;
        logic direction;
        logic standstill;
    } gcd_events_t;

    // Enable states of the voltage chopper mode.
    typedef enum logic [1:0] {
        GCD_PWM_OFF,
        GCD_PWM_PENDING,
        GCD_PWM_ON
    } gcd_pwm_state_t;

endpackage

// ===== logic/gcd_pin_driver.sv
// Output stage that turns a logical active level into open-collector or push-pull drive.
module gcd_pin_driver
    import gcd_pkg::*;
(
    input  wire logic clk_i,       // Device clock.
    input  wire logic srst_i,      // Synchronous reset, active high.
    input  wire logic active_i,    // Logical active state of the output.
    input  wire logic pushpull_i,  // Set selects push-pull, active high.
    input  wire logic in_reset_i,  // Reset indication forces active low drive.
    output logic      pin_o,       // Level driven onto the pin.
    output logic      pin_oe_n_o   // Output enable, low while driving.
);

    logic next_pin;     // Next driven level.
    logic next_oe_n;    // Next output enable, active low.

    // Work out drive level and enable for the pin.
    always_comb begin
        if (in_reset_i) begin
            // Reset shows as a driven low level in either mode.
            next_pin  = 1'b0;
            next_oe_n = 1'b0;
        end else if (pushpull_i) begin
            // Push-pull drives the active state high.
            next_pin  = active_i;
            next_oe_n = 1'b0;
        end else begin
            // Open collector pulls low when active and releases otherwise.
            next_pin  = 1'b0;
            next_oe_n = ~active_i;
        end
    end

    // Register the pin signals so the pins come from flip-flops.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pin_o      <= 1'b0;
            pin_oe_n_o <= 1'b0;
        end else begin
            pin_o      <= next_pin;
            pin_oe_n_o <= next_oe_n;
        end
    end

endmodule

// ===== logic/gcd_global_config.sv
// Global configuration register with diagnostic output routing.
// What this block does
// - All registers read zero after power-up.
// - Configuration at 0x00, 17 bits, read/write.
// - Bit 0 picks analog reference input.
// - Bit 1 picks internal sense resistors.
// - Bit 2 PWM mode; enables only at standstill.
// - Bit 3 encoder commutation; software keeps zero.
// - Bit 4 inverts motor direction.
// - Bit 5 routes driver errors to A.
// - Output A driven low during reset.
// - Bit 6 routes prewarning to A.
// - Bit 7 routes stall to A.
// - Strap low: A is interrupt or step.
// - Bit 8 routes stall to B.
// - Strap low: B is compare or direction.
// - Bit 9 routes index position to B.
// - Bit 10 routes chopper on-state to B.
// - Bit 11 toggles B on skipped steps.
// - Outputs open collector unless push-pull set.
module gcd_global_config
    import gcd_pkg::*;
(
    input  wire logic        clk_i,                      // Device clock, 25 MHz.
    input  wire logic        srst_i,                     // Synchronous reset, active high.
    input  wire gcd_req_t    req_i,                      // Register access request.
    input  wire gcd_events_t events_i,                   // Internal event sources.
    input  wire logic        step_direction_mode_strap_i, // Mode strap level.
    output gcd_rsp_t         rsp_o,                      // Read answer.
    output logic [16:0]      global_configuration_o,     // Register contents.
    output logic             use_analog_reference_o,     // Analog reference selected.
    output logic             internal_sense_o,           // Internal sense resistors selected.
    output logic             pwm_mode_active_o,          // Voltage chopper mode in effect.
    output logic             encoder_commutation_o,      // Encoder commutation enabled.
    output logic             invert_direction_o,         // Motor direction inverted.
    output logic             diagnostic_output_a_o,      // Level on output A.
    output logic             diagnostic_output_a_oe_n_o, // Output A enable, low drives.
    output logic             diagnostic_output_b_o,      // Level on output B.
    output logic             diagnostic_output_b_oe_n_o  // Output B enable, low drives.
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and access.
    ////////////////////////////////////////////////////////////////////////////

    logic [16:0]    conf;            // Stored configuration.
    logic [16:0]    next_conf;       // Next configuration.
    gcd_rsp_t       next_rsp;        // Next read answer.
    logic           is_write;        // Access carries the write flag.
    logic [7:0]     reg_addr;        // Address with write flag removed.

    assign is_write = req_i.addr[GCD_WRITE_BIT];
    assign reg_addr = req_i.addr & ~GCD_WRITE_FLAG;

    // Decode writes and reads of the configuration word.
    always_comb begin
        next_conf = conf;
        next_rsp  = '{valid: 1'b0, rdata: 32'h0000_0000};
        if (req_i.valid && reg_addr == GCD_ADDR_GLOBAL_CONFIGURATION) begin
            if (is_write) begin
                // Only the 17 implemented bits are stored.
                next_conf = req_i.wdata[GCD_CONF_WIDTH-1:0];
            end else begin
                // Reads return the stored word zero extended.
                next_rsp.valid = 1'b1;
                next_rsp.rdata = {15'h0000, conf};
            end
        end else if (req_i.valid && !is_write) begin
            // Unmapped reads answer with zero.
            next_rsp.valid = 1'b1;
        end
    end

    // Register storage; reset clears everything.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conf  <= GCD_CONF_RESET;
            rsp_o <= '{valid: 1'b0, rdata: 32'h0000_0000};
        end else begin
            conf  <= next_conf;
            rsp_o <= next_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Voltage chopper enable sequencing.
    ////////////////////////////////////////////////////////////////////////////

    gcd_pwm_state_t pwm_state;       // Current chopper mode state.
    gcd_pwm_state_t next_pwm_state;  // Next chopper mode state.

    // A request to switch on waits for standstill; switching off is immediate.
    always_comb begin
        next_pwm_state = pwm_state;
        case (pwm_state)
            GCD_PWM_OFF: begin
                if (conf[GCD_B_PWM_MODE]) begin
                    next_pwm_state = events_i.standstill ? GCD_PWM_ON : GCD_PWM_PENDING;
                end
            end
            GCD_PWM_PENDING: begin
                if (!conf[GCD_B_PWM_MODE]) begin
                    next_pwm_state = GCD_PWM_OFF;
                end else if (events_i.standstill) begin
                    next_pwm_state = GCD_PWM_ON;
                end
            end
            GCD_PWM_ON: begin
                if (!conf[GCD_B_PWM_MODE]) begin
                    next_pwm_state = GCD_PWM_OFF;
                end
            end
            default: begin
                next_pwm_state = GCD_PWM_OFF;
            end
        endcase
    end

    // Register the chopper state.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwm_state <= GCD_PWM_OFF;
        end else begin
            pwm_state <= next_pwm_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs.
    ////////////////////////////////////////////////////////////////////////////

    logic [4:0] next_ctrl;  // Next values of the five control outputs.

    // Collect control bits from the configuration.
    always_comb begin
        next_ctrl[0] = next_conf[GCD_B_SCALE_ANALOG];
        next_ctrl[1] = next_conf[GCD_B_INTERNAL_SENSE];
        next_ctrl[2] = (next_pwm_state == GCD_PWM_ON);
        next_ctrl[3] = next_conf[GCD_B_ENC_COMMUTATION];
        next_ctrl[4] = next_conf[GCD_B_INVERT_DIRECTION];
    end

    // Register control outputs.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            global_configuration_o <= GCD_CONF_RESET;
            use_analog_reference_o <= 1'b0;
            internal_sense_o       <= 1'b0;
            pwm_mode_active_o      <= 1'b0;
            encoder_commutation_o  <= 1'b0;
            invert_direction_o     <= 1'b0;
        end else begin
            global_configuration_o <= next_conf;
            use_analog_reference_o <= next_ctrl[0];
            internal_sense_o       <= next_ctrl[1];
            pwm_mode_active_o      <= next_ctrl[2];
            encoder_commutation_o  <= next_ctrl[3];
            invert_direction_o     <= next_ctrl[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Diagnostic routing.
    ////////////////////////////////////////////////////////////////////////////

    logic skip_toggle;       // Toggle state for skipped steps.
    logic next_skip_toggle;  // Next toggle state.
    logic active_a;          // Logical active state of output A.
    logic active_b;          // Logical active state of output B.

    // Flip the toggle on every skipped-step increment while enabled.
    always_comb begin
        next_skip_toggle = skip_toggle;
        if (conf[GCD_B_B_TOGGLE_SKIP] && events_i.skip_increment) begin
            next_skip_toggle = ~skip_toggle;
        end
    end

    // Register the toggle.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            skip_toggle <= 1'b0;
        end else begin
            skip_toggle <= next_skip_toggle;
        end
    end

    // Combine the enabled sources for each output.
    always_comb begin
        if (step_direction_mode_strap_i) begin
            active_a = (conf[GCD_B_A_DRIVER_ERROR] &&
                        (events_i.overtemperature || events_i.short_to_ground ||
                         events_i.charge_pump_undervoltage))
                     || (conf[GCD_B_A_PREWARNING] && events_i.prewarning)
                     || (conf[GCD_B_A_STALL_STEP] && events_i.stall);
            active_b = (conf[GCD_B_B_STALL_DIRECTION] && events_i.stall)
                     || (conf[GCD_B_B_INDEX] && events_i.index)
                     || (conf[GCD_B_B_CHOPPER_ON] && events_i.chopper_on)
                     || (conf[GCD_B_B_TOGGLE_SKIP] && skip_toggle);
        end else begin
            // External driver mode: pass step and direction or the status signals.
            active_a = conf[GCD_B_A_STALL_STEP] ? events_i.step_toggle
                                                : events_i.interrupt;
            active_b = conf[GCD_B_B_STALL_DIRECTION] ? events_i.direction
                                                     : events_i.position_compare;
        end
    end

    // Per-output signals of the output stages; index 0 is A, index 1 is B.
    logic [1:0] pin_active;    // Logical active state per output.
    logic [1:0] pin_pushpull;  // Push-pull selection per output.
    logic [1:0] pin_in_reset;  // Reset indication per output.
    logic [1:0] pin_level;     // Registered pin levels.
    logic [1:0] pin_oe_n;      // Registered output enables, low drives.

    assign pin_active   = {active_b, active_a};
    assign pin_pushpull = {conf[GCD_B_B_PUSHPULL], conf[GCD_B_A_PUSHPULL]};
    assign pin_in_reset = {1'b0, srst_i};  // Only output A takes the reset indication; both stages reset to driven low.

    // One output stage per diagnostic output.
    for (genvar g = 0; g < 2; g++) begin : g_drv
        gcd_pin_driver u_drv (
            .clk_i      (clk_i),
            .srst_i     (srst_i),
            .active_i   (pin_active[g]),
            .pushpull_i (pin_pushpull[g]),
            .in_reset_i (pin_in_reset[g]),
            .pin_o      (pin_level[g]),
            .pin_oe_n_o (pin_oe_n[g])
        );
    end

    // Pins come straight from the output stage flip-flops.
    assign diagnostic_output_a_o      = pin_level[0];
    assign diagnostic_output_a_oe_n_o = pin_oe_n[0];
    assign diagnostic_output_b_o      = pin_level[1];
    assign diagnostic_output_b_oe_n_o = pin_oe_n[1];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    ////////////////////////////////////////////////////////////////////////////

    // Accepted write of the configuration word, seen from the request side.
    logic conf_write;
    assign conf_write = req_i.valid && is_write && (reg_addr == GCD_ADDR_GLOBAL_CONFIGURATION);

    // All checks but the reset ones are off while reset is held.
    a_reset_clears_conf: assert property (@(posedge clk_i)
        srst_i |=> (global_configuration_o == 17'h0_0000))
        else $error("configuration not cleared by reset");

    a_write_stores_word: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.addr == 8'h80) |=> (conf == $past(req_i.wdata[16:0])))
        else $error("write did not store configuration");

    a_read_returns_conf: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && req_i.addr == 8'h00)
        |=> (rsp_o.valid && rsp_o.rdata == {15'h0000, $past(conf)}))
        else $error("read answer wrong");

    a_pwm_only_standstill: assert property (@(posedge clk_i) disable iff (srst_i)
        (!pwm_mode_active_o ##1 pwm_mode_active_o) |-> $past(events_i.standstill))
        else $error("chopper mode enabled while moving");

    a_direction_follows: assert property (@(posedge clk_i) disable iff (srst_i)
        conf_write |=> (invert_direction_o == $past(req_i.wdata[GCD_B_INVERT_DIRECTION])))
        else $error("direction inversion stale");

    a_out_a_in_reset: assert property (@(posedge clk_i)
        srst_i [*2] |-> (!diagnostic_output_a_o && !diagnostic_output_a_oe_n_o))
        else $error("output A not driven low in reset");

    a_prewarning_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[6] && events_i.prewarning && !conf[12])
        |=> !diagnostic_output_a_oe_n_o && !diagnostic_output_a_o)
        else $error("prewarning not shown on output A");

    a_step_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (!step_direction_mode_strap_i && conf[7] && conf[12])
        |=> diagnostic_output_a_o == $past(events_i.step_toggle))
        else $error("step not passed to output A");

    a_index_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[9] && events_i.index && conf[13])
        |=> diagnostic_output_b_o)
        else $error("index not shown on output B");

    a_idle_released: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[11:5] == 7'h00 && !conf[12])
        |=> diagnostic_output_a_oe_n_o)
        else $error("output A driven while idle");

    a_refused_write_kept: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && is_write && !conf_write) |=> $stable(conf))
        else $error("unmapped write changed configuration");

    a_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        (req_i.valid && !is_write && reg_addr != GCD_ADDR_GLOBAL_CONFIGURATION)
        |=> (rsp_o.valid && rsp_o.rdata == 32'h0000_0000))
        else $error("unmapped read answer wrong");

    a_analog_ref_follows: assert property (@(posedge clk_i) disable iff (srst_i)
        conf_write |=> (use_analog_reference_o == $past(req_i.wdata[GCD_B_SCALE_ANALOG])))
        else $error("reference selection stale");

    a_sense_follows: assert property (@(posedge clk_i) disable iff (srst_i)
        conf_write |=> (internal_sense_o == $past(req_i.wdata[GCD_B_INTERNAL_SENSE])))
        else $error("sense selection stale");

    a_encoder_follows: assert property (@(posedge clk_i) disable iff (srst_i)
        conf_write |=> (encoder_commutation_o == $past(req_i.wdata[GCD_B_ENC_COMMUTATION])))
        else $error("encoder commutation stale");

    a_pwm_drops_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (pwm_mode_active_o && !conf[GCD_B_PWM_MODE]) |=> !pwm_mode_active_o)
        else $error("chopper mode kept after clear");

    a_driver_error_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[GCD_B_A_DRIVER_ERROR] && !conf[GCD_B_A_PUSHPULL]
         && (events_i.overtemperature || events_i.short_to_ground)) |=> !diagnostic_output_a_oe_n_o)
        else $error("driver error not shown on output A");

    a_stall_a_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[GCD_B_A_STALL_STEP] && events_i.stall
         && !conf[GCD_B_A_PUSHPULL]) |=> !diagnostic_output_a_oe_n_o)
        else $error("stall not shown on output A");

    a_stall_b_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[GCD_B_B_STALL_DIRECTION] && events_i.stall
         && conf[GCD_B_B_PUSHPULL]) |=> diagnostic_output_b_o)
        else $error("stall not shown on output B");

    a_chopper_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (step_direction_mode_strap_i && conf[GCD_B_B_CHOPPER_ON] && events_i.chopper_on
         && conf[GCD_B_B_PUSHPULL]) |=> diagnostic_output_b_o)
        else $error("chopper state not shown on output B");

    a_direction_routed: assert property (@(posedge clk_i) disable iff (srst_i)
        (!step_direction_mode_strap_i && conf[GCD_B_B_STALL_DIRECTION] && conf[GCD_B_B_PUSHPULL])
        |=> (diagnostic_output_b_o == $past(events_i.direction)))
        else $error("direction not passed to output B");

    c_write_conf: cover property (@(posedge clk_i) req_i.valid && req_i.addr == 8'h80);
    c_pwm_pending: cover property (@(posedge clk_i) pwm_state == GCD_PWM_PENDING);
    c_skip_toggle: cover property (@(posedge clk_i) skip_toggle ##1 !skip_toggle);
    c_ext_driver: cover property (@(posedge clk_i) !step_direction_mode_strap_i && conf[7]);
    c_pwm_on: cover property (@(posedge clk_i) pwm_mode_active_o);

endmodule

// ===== testbench/gcd_host_model.sv
// Host model that issues register accesses toward the global configuration block.
module gcd_host_model
    import gcd_pkg::*;
(
    input  wire logic     clk_i,  // Device clock.
    input  wire gcd_rsp_t rsp_i,  // Read answer from the block.
    output gcd_req_t      req_o   // Request toward the block.
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus starts idle.
    initial req_o = '{valid: 1'b0, addr: 8'h00, wdata: 32'h0000_0000};

    // One write: the write flag is added to the register address.
    task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_i);
        req_o <= '{valid: 1'b1, addr: addr | GCD_WRITE_FLAG, wdata: data};
        @(posedge clk_i);
        // Released fields show the inverse so that stale values are never trusted.
        req_o <= '{valid: 1'b0, addr: ~(addr | GCD_WRITE_FLAG), wdata: ~data};
    endtask

    // One read: bit 7 stays clear and the answer is taken one cycle later.
    task automatic read_reg(input logic [7:0] addr, output logic ok, output logic [31:0] data);
        @(posedge clk_i);
        req_o <= '{valid: 1'b1, addr: addr & ~GCD_WRITE_FLAG, wdata: 32'h5555_AAAA};
        @(posedge clk_i);
        req_o <= '{valid: 1'b0, addr: ~addr, wdata: 32'hAAAA_5555};
        @(posedge clk_i);
        ok = rsp_i.valid;
        data = rsp_i.rdata;
    endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking testbench of the global configuration block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gcd_pkg::*;

    logic        clk_i;      // Device clock, 40 ns period.
    logic        srst_i;     // Synchronous reset.
    gcd_req_t    req;        // Request from the host model.
    gcd_rsp_t    rsp;        // Read answer.
    gcd_events_t ev;         // Event sources driven by the bench.
    logic        strap;      // Mode strap level.
    logic [16:0] conf_o;     // Register copy.
    logic        use_ar, isense, pwm_act, enc, inv; // Control outputs.
    logic        pin_a, oe_a, pin_b, oe_b;           // Diagnostic pins.
    int          fail_count = 0; // Mismatches seen.
    int          n_compared = 0; // Comparisons made.

    // Routing table: register mask, event position, strap level, output B selected.
    localparam logic [16:0] T_MASK [13] = '{17'h0_0020, 17'h0_0020, 17'h0_0020, 17'h0_0040,
        17'h0_0080, 17'h0_0100, 17'h0_0200, 17'h0_0400, 17'h0_4000, 17'h0_0080, 17'h0_4000,
        17'h0_0100, 17'h0_0060};
    localparam int T_EV    [13] = '{12, 11, 10, 9, 8, 8, 7, 6, 4, 2, 3, 1, 9};
    localparam int T_STRAP [13] = '{1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 1};
    localparam int T_OUTB  [13] = '{0, 0, 0, 0, 0, 1, 1, 1, 0, 0, 1, 1, 0};

    gcd_host_model i_host (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));

    gcd_global_config i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .req_i(req), .events_i(ev),
        .step_direction_mode_strap_i(strap), .rsp_o(rsp), .global_configuration_o(conf_o),
        .use_analog_reference_o(use_ar), .internal_sense_o(isense),
        .pwm_mode_active_o(pwm_act), .encoder_commutation_o(enc),
        .invert_direction_o(inv), .diagnostic_output_a_o(pin_a),
        .diagnostic_output_a_oe_n_o(oe_a), .diagnostic_output_b_o(pin_b),
        .diagnostic_output_b_oe_n_o(oe_b));

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Reads one address and compares the answer.
    task automatic check_read(input logic [7:0] addr, input logic [31:0] exp);
        logic        ok;
        logic [31:0] data;
        i_host.read_reg(addr, ok, data);
        check(32'(ok), 32'h0000_0001);
        check(data, exp);
    endtask

    // Compares one diagnostic pin against its drive style and active state.
    task automatic check_pin(input int outb, input logic pp, input logic act);
        logic pin;
        logic oe_n;
        pin = (outb != 0) ? pin_b : pin_a;
        oe_n = (outb != 0) ? oe_b : oe_a;
        check(32'(oe_n), pp ? 32'h0000_0000 : 32'(!act));
        if (pp || act) check(32'(pin), 32'(pp & act));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Register access: reset value, width, refused write, unmapped read, control bits.
    task automatic test_registers();
        check_read(8'h00, 32'h0000_0000);
        i_host.write_reg(8'h00, 32'hFFFF_FFFB);
        check_read(8'h00, 32'h0001_FFFB);
        check(32'({use_ar, isense, enc, inv}), 32'h0000_000F);
        check(32'(conf_o), 32'h0001_FFFB);
        i_host.write_reg(8'h01, 32'h0000_0000);
        check_read(8'h00, 32'h0001_FFFB);
        check_read(8'h05, 32'h0000_0000);
        i_host.write_reg(8'h00, 32'h0000_0000);
        @(posedge clk_i);
        check(32'({use_ar, isense, enc, inv}), 32'h0000_0000);
    endtask

    // The voltage chopper mode switches on only at standstill and drops when cleared.
    task automatic test_pwm();
        @(posedge clk_i);
        ev <= '0;
        i_host.write_reg(8'h00, 32'h0000_0004);
        repeat (3) @(posedge clk_i);
        check(32'(pwm_act), 32'h0000_0000);
        ev <= gcd_events_t'(13'h0001);
        repeat (3) @(posedge clk_i);
        check(32'(pwm_act), 32'h0000_0001);
        i_host.write_reg(8'h00, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        check(32'(pwm_act), 32'h0000_0000);
    endtask

    // Every routing but the skipped-step toggle, in both drive styles, with its event off and then on.
    task automatic test_routing();
        logic [16:0] conf;
        for (int i = 0; i < 13; i++) begin
            for (int pp = 0; pp < 2; pp++) begin
                conf = T_MASK[i];
                conf[GCD_B_A_PUSHPULL + T_OUTB[i]] = pp[0];
                @(posedge clk_i);
                strap <= T_STRAP[i][0];
                ev <= '0;
                i_host.write_reg(8'h00, 32'(conf));
                repeat (3) @(posedge clk_i);
                check_pin(T_OUTB[i], pp[0], 1'b0);
                ev <= gcd_events_t'(13'(1) << T_EV[i]);
                repeat (3) @(posedge clk_i);
                check_pin(T_OUTB[i], pp[0], 1'b1);
            end
        end
    endtask

    // Output B toggles on each skipped-step pulse, seen in push-pull drive.
    task automatic test_skip();
        @(posedge clk_i);
        strap <= 1'b1;
        ev <= '0;
        i_host.write_reg(8'h00, 32'h0000_2800);
        repeat (3) @(posedge clk_i);
        check(32'(pin_b), 32'h0000_0000);
        for (int k = 1; k <= 2; k++) begin
            ev <= gcd_events_t'(13'h0020);
            @(posedge clk_i);
            ev <= '0;
            repeat (3) @(posedge clk_i);
            check(32'(pin_b), 32'(k % 2));
        end
    endtask

    // A reset in mid-run clears the word and drives output A low while held.
    task automatic test_reset();
        @(posedge clk_i);
        strap <= 1'b1;
        ev <= gcd_events_t'(13'h1000);
        i_host.write_reg(8'h00, 32'h0000_1020);
        repeat (3) @(posedge clk_i);
        check(32'({pin_a, oe_a}), 32'h0000_0002);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(32'({pin_a, oe_a}), 32'h0000_0000);
        check(32'(conf_o), 32'h0000_0000);
        srst_i <= 1'b0;
        ev <= '0;
        check_read(8'h00, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Clock of 25 MHz.
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Reset for two cycles, output A low during it, then the scenarios.
    initial begin
        srst_i = 1'b1;
        ev = '0;
        strap = 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        check(32'({pin_a, oe_a}), 32'h0000_0000);
        srst_i <= 1'b0;
        test_registers();
        test_pwm();
        test_routing();
        test_skip();
        test_reset();
        complete_run();
    end

    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
endmodule
